//--- logic/cmpd_pkg.sv
// constants for the clock mode and power-down control block
package cmpd_pkg;
  localparam logic [11:0] ADDR_CLKMODE = 12'h000;
  localparam logic [11:0] ADDR_RTCTRL  = 12'h004;
  localparam logic [11:0] ADDR_STATUS  = 12'h008;
  localparam logic [11:0] ADDR_CMD     = 12'h00c;
  localparam int CM_HLSEL  = 0;
  localparam int CM_IDLE   = 1;
  localparam int CM_LCD_CLOCK_ENABLE  = 2;
  localparam int CM_DIV_LO = 5;
  localparam int RT_QSTART = 4;
  localparam int ST_PDF    = 0;
  localparam int ST_TO     = 1;
  localparam int ST_MODE_LO = 4;
  localparam int CMD_HALT  = 0;
  localparam int CMD_WAKE  = 1;
  localparam int CMD_CLRWD = 2;
  localparam int CMD_WDTO  = 3;
  localparam logic [7:0] CLKMODE_RST = 8'h03;
  localparam int LCD_DIV   = 8;
  localparam int SYS4_DIV  = 4;
  localparam int WAKE_CYCLES = 1024;
  typedef enum logic [1:0] {
    CMPD_NORMAL, CMPD_SLOW, CMPD_IDLE, CMPD_SLEEP
  } cmpd_mode_t;
endpackage : cmpd_pkg

//--- logic/cmpd_divider.sv
// enable-pulse divider: tick once every ratio input ticks
`timescale 1ns/10ps
`default_nettype none
module cmpd_divider #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // control
  input  wire logic         run,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio_m1,
  // result
  output logic              tick_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } cmpd_div_state_t;
  cmpd_div_state_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = '0;
    end else if (tick_in) begin
      if (s_reg.cnt >= ratio_m1) begin
        s_next.cnt  = '0;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + W'(1);
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign tick_out = s_reg.tick;
endmodule : cmpd_divider
`default_nettype wire

//--- logic/cmpd_clock_ctrl.sv
// clock source, operating mode and power-down control with apb registers
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cmpd_clock_ctrl #(
  parameter int  WAKE_WAIT = cmpd_pkg::WAKE_CYCLES,
  parameter bit  SUB_FROM_RC = 1'b1,
  parameter bit  PERIPH_FROM_SUB = 1'b1,
  parameter bit  WDT_FROM_OWN_OSC = 1'b1,
  parameter bit  EXT_CLOCK_MODE = 1'b0,
  parameter bit  EXT_FILTER_ON = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator ticks, synchronous one-cycle enables
  input  wire logic        high_osc_tick,
  input  wire logic        high_osc_input_pin,
  input  wire logic        sub_crystal_tick,
  input  wire logic        internal_low_freq_rc,
  input  wire logic        wdt_osc_tick,
  // cpu events
  input  wire logic        halt_exec,
  input  wire logic        wake_event,
  // clock enables and state out
  output logic             high_clock,
  output logic             slow_clock,
  output logic             system_clock,
  output logic             sub_clock,
  output logic             peripheral_clock,
  output logic             lcd_clock,
  output logic             watchdog_clock,
  output logic             cpu_run,
  output logic             hold_state,
  output logic             quick_start_control,
  output logic             ext_filter_enable,
  output logic             wdt_clear,
  output logic [1:0]       op_mode
);
  typedef enum logic [1:0] {ST_RUN, ST_DOWN, ST_WAKE} cmpd_pd_t;
  typedef struct packed {
    logic [7:0]  clkmode;
    logic        qstart;
    logic        power_down_flag;
    logic        to;
    cmpd_pd_t    pd;
    logic [10:0] wcnt;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        hclk, sclk, sysclk, subclk, pclk, lclk, wclk;
    logic [1:0]  sys4cnt;
    logic        wclr;
  } cmpd_state_t;
  cmpd_state_t s_reg, s_next;
  logic sub_src, slow_tick, lcd_tick, hi_src, hi_run;
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction : addr_hit
  assign sub_src = SUB_FROM_RC ? internal_low_freq_rc
                               : sub_crystal_tick;
  assign hi_src  = EXT_CLOCK_MODE ? high_osc_input_pin : high_osc_tick;
  assign hi_run  = (s_reg.pd != ST_DOWN);
  cmpd_divider #(.W(6)) u_slow (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .run      (hi_run),
    .tick_in  (hi_src),
    .ratio_m1 (6'((7'd2 << s_reg.clkmode[cmpd_pkg::CM_DIV_LO +: 3]) - 7'd1)),
    .tick_out (slow_tick)
  );
  cmpd_divider #(.W(3)) u_lcd (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .run      (1'b1),
    .tick_in  (sub_src),
    .ratio_m1 (3'(cmpd_pkg::LCD_DIV - 1)),
    .tick_out (lcd_tick)
  );
  always_comb begin
    logic [1:0]  wr_mode;
    logic        sys_t;
    logic        sys4;
    wr_mode = 2'b00;
    sys_t = 1'b0;
    sys4 = 1'b0;
    s_next = s_reg;
    s_next.ready = 1'b0;
    s_next.err = 1'b0;
    s_next.wclr = 1'b0;
    // apb: one wait state, answer in access phase
    if (psel && penable && !s_reg.ready) begin
      s_next.ready = 1'b1;
      s_next.rdata = '0;
      if (addr_hit(paddr, cmpd_pkg::ADDR_CLKMODE)) begin
        s_next.rdata[7:0] = s_reg.clkmode;
        if (pwrite) s_next.clkmode = pwdata[7:0];
      end else if (addr_hit(paddr, cmpd_pkg::ADDR_RTCTRL)) begin
        s_next.rdata[cmpd_pkg::RT_QSTART] = s_reg.qstart;
        if (pwrite) s_next.qstart = pwdata[cmpd_pkg::RT_QSTART];
      end else if (addr_hit(paddr, cmpd_pkg::ADDR_STATUS)) begin
        s_next.rdata[cmpd_pkg::ST_PDF] = s_reg.power_down_flag;
        s_next.rdata[cmpd_pkg::ST_TO]  = s_reg.to;
        s_next.rdata[cmpd_pkg::ST_MODE_LO +: 2] = op_mode;
      end else if (addr_hit(paddr, cmpd_pkg::ADDR_CMD)) begin
        if (pwrite && pwdata[cmpd_pkg::CMD_CLRWD]) begin
          s_next.power_down_flag = 1'b0;
          s_next.to = 1'b0;
          s_next.wclr = 1'b1;
        end
        if (pwrite && pwdata[cmpd_pkg::CMD_WDTO]) s_next.to = 1'b1;
        if (pwrite && pwdata[cmpd_pkg::CMD_HALT]) wr_mode[0] = 1'b1;
        if (pwrite && pwdata[cmpd_pkg::CMD_WAKE]) wr_mode[1] = 1'b1;
      end else begin
        s_next.err = 1'b1;
      end
    end
    // power-down sequencing
    case (s_reg.pd)
      ST_RUN: begin
        if (halt_exec || wr_mode[0]) begin
          s_next.pd = ST_DOWN;
          s_next.power_down_flag = 1'b1;
          s_next.to = 1'b0;
          s_next.wclr = 1'b1;
        end
      end
      ST_DOWN: begin
        if (wake_event || wr_mode[1]) begin
          s_next.pd = ST_WAKE;
          s_next.wcnt = '0;
        end
      end
      ST_WAKE: begin
        if (s_reg.sysclk) s_next.wcnt = s_reg.wcnt + 11'd1;
        if (s_reg.wcnt >= 11'(WAKE_WAIT)) s_next.pd = ST_RUN;
      end
      default: s_next.pd = ST_RUN;
    endcase
    // clock enables
    sys_t = s_reg.clkmode[cmpd_pkg::CM_HLSEL] ? hi_src : slow_tick;
    if (s_reg.pd == ST_DOWN) sys_t = 1'b0;
    s_next.hclk = hi_run & hi_src;
    s_next.sclk = hi_run & slow_tick;
    s_next.sysclk = sys_t;
    s_next.subclk = sub_src;
    if (sys_t) s_next.sys4cnt = s_reg.sys4cnt + 2'd1;
    sys4 = sys_t && (s_reg.sys4cnt == 2'(cmpd_pkg::SYS4_DIV - 1));
    s_next.pclk = PERIPH_FROM_SUB ? sub_src : sys4;
    s_next.lclk = lcd_tick && s_reg.clkmode[cmpd_pkg::CM_LCD_CLOCK_ENABLE];
    s_next.wclk = WDT_FROM_OWN_OSC ? wdt_osc_tick : sys4;
    if (s_reg.pd == ST_DOWN && !s_reg.clkmode[cmpd_pkg::CM_IDLE]) begin
      s_next.pclk = 1'b0;
      s_next.lclk = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.clkmode <= cmpd_pkg::CLKMODE_RST;
      s_reg.pd <= ST_RUN;
    end else begin
      s_reg <= s_next;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      op_mode <= 2'(cmpd_pkg::CMPD_NORMAL);
    end else if (s_next.pd == ST_DOWN) begin
      op_mode <= s_next.clkmode[cmpd_pkg::CM_IDLE] ? 2'(cmpd_pkg::CMPD_IDLE)
                 : 2'(cmpd_pkg::CMPD_SLEEP);
    end else begin
      op_mode <= s_next.clkmode[cmpd_pkg::CM_HLSEL]
                 ? 2'(cmpd_pkg::CMPD_NORMAL) : 2'(cmpd_pkg::CMPD_SLOW);
    end
  end
  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign high_clock = s_reg.hclk;
  assign slow_clock = s_reg.sclk;
  assign system_clock = s_reg.sysclk;
  assign sub_clock = s_reg.subclk;
  assign peripheral_clock = s_reg.pclk;
  assign lcd_clock = s_reg.lclk;
  assign watchdog_clock = s_reg.wclk;
  assign cpu_run = (s_reg.pd == ST_RUN);
  assign hold_state = (s_reg.pd != ST_RUN);
  assign quick_start_control = s_reg.qstart;
  assign ext_filter_enable = EXT_FILTER_ON;
  assign wdt_clear = s_reg.wclr;
endmodule : cmpd_clock_ctrl
`default_nettype wire

//--- dv/cmpd_assertions.sv
// concurrent checks on the clock mode and power-down block ports
`timescale 1ns/10ps
`default_nettype none
module cmpd_assertions #(
  parameter int WAKE_WAIT = 4
) (
  // clock, reset and events
  input wire logic       sys_clk, resetn, halt_exec, wake_event,
  input wire logic       internal_low_freq_rc, wdt_osc_tick,
  // state and clock enables
  input wire logic       cpu_run, hold_state, wdt_clear, system_clock,
  input wire logic       high_clock, slow_clock, sub_clock, lcd_clock,
  input wire logic       peripheral_clock, watchdog_clock,
  input wire logic [1:0] op_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  int   cnt;
  logic woke;
  // counts system clock pulses of the wake wait
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt  <= 0;
      woke <= 1'b0;
    end else if (wake_event && !cpu_run) begin
      cnt  <= 0;
      woke <= 1'b1;
    end else if (cpu_run) begin
      woke <= 1'b0;
    end else if (system_clock) begin
      cnt <= cnt + 1;
    end
  end
  halt_wdclr_a: assert property (halt_exec && cpu_run |=> wdt_clear)
    else $error("no watchdog clear on halt");
  halt_stop_a: assert property (halt_exec && cpu_run |=> !cpu_run && hold_state)
    else $error("cpu not stopped on halt");
  down_clk_a: assert property (halt_exec && cpu_run |=> ##1
    (!system_clock && !high_clock && !slow_clock)[*4])
    else $error("system clocks run in power-down");
  sleep_off_a: assert property (halt_exec && cpu_run ##1 op_mode == 2'd3
    |=> (!lcd_clock && !peripheral_clock)[*4])
    else $error("lcd or peripheral clock runs in sleep");
  sub_runs_a: assert property (internal_low_freq_rc |=> sub_clock)
    else $error("sub clock missed an rc tick");
  idle_per_a: assert property (op_mode == 2'd2 && sub_clock |-> peripheral_clock)
    else $error("peripheral clock stopped in idle");
  wdt_own_a: assert property (!cpu_run && wdt_osc_tick |=> watchdog_clock)
    else $error("watchdog clock stopped in power-down");
  wake_wait_a: assert property ($rose(cpu_run) && woke |->
    cnt >= WAKE_WAIT && cnt <= WAKE_WAIT + 1)
    else $error("wake wait length wrong");
endmodule : cmpd_assertions
bind cmpd_clock_ctrl cmpd_assertions #(.WAKE_WAIT(WAKE_WAIT)) i_cmpd_assertions (.*);
`default_nettype wire

//--- dv/cmpd_osc_model.sv
// oscillator model: free-running enable ticks of all clock sources
`timescale 1ns/10ps
`default_nettype none
module cmpd_osc_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // oscillator ticks
  output logic     high_osc_tick,
  output logic     high_osc_input_pin,
  output logic     sub_crystal_tick,
  output logic     internal_low_freq_rc,
  output logic     wdt_osc_tick
);
  logic [3:0] ph;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ph <= 4'h0;
    else ph <= ph + 4'h1;
  end
  // oscillators run whatever the quick-start setting
  assign high_osc_tick        = ph[0];
  assign high_osc_input_pin   = ph[0];
  assign sub_crystal_tick     = ph[2:0] == 3'h3;
  assign internal_low_freq_rc = ph[2:0] == 3'h5;
  assign wdt_osc_tick         = ph == 4'h9;
endmodule : cmpd_osc_model
`default_nettype wire

//--- dv/clock_mode_power_down_control_bench.sv
// self-checking bench for the clock mode and power-down block
`timescale 1ns/10ps
`default_nettype none
module clock_mode_power_down_control_bench;
  logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic halt_exec = 0, wake_event = 0, cnt_en = 0, pready, pslverr;
  logic high_osc_tick, high_osc_input_pin, sub_crystal_tick;
  logic internal_low_freq_rc, wdt_osc_tick, high_clock, slow_clock;
  logic system_clock, sub_clock, peripheral_clock, lcd_clock;
  logic watchdog_clock, cpu_run, hold_state, quick_start_control;
  logic ext_filter_enable, wdt_clear;
  logic [1:0]  op_mode;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, rnd = 32'd65;
  logic [32:0] q[$];
  int n_fail = 0, n_checks = 0, c_sy, c_lc, c_su, c_pe;
  cmpd_clock_ctrl #(.WAKE_WAIT(4)) i_cmpd_clock_ctrl (.*);
  cmpd_osc_model i_cmpd_osc_model (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs;
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (!pready && k < 40);
    if (!pready) begin n_fail++; close_out(); end
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // read results are compared against the oldest note
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, q.pop_front());
  end
  always @(posedge sys_clk) begin
    if (cnt_en) begin
      c_sy += system_clock; c_lc += lcd_clock;
      c_su += sub_clock; c_pe += peripheral_clock;
    end
  end
  task automatic run(input int n);
    c_sy = 0; c_lc = 0; c_su = 0; c_pe = 0;
    cnt_en <= 1;
    repeat (n) @(posedge sys_clk);
    cnt_en <= 0;
  endtask : run
  task automatic halt;
    @(posedge sys_clk) halt_exec <= 1;
    @(posedge sys_clk) halt_exec <= 0;
    repeat (2) @(posedge sys_clk);
    run(256);
  endtask : halt
  task automatic wake;
    int k;
    repeat (xs() % 8) @(posedge sys_clk);
    @(posedge sys_clk) wake_event <= 1;
    @(posedge sys_clk) wake_event <= 0;
    for (k = 0; k < 300 && !cpu_run; k++) @(posedge sys_clk);
    chk(cpu_run === 1'b1 && k > 4, 1);
    $display("test wake done");
  endtask : wake
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1;
    rd(12'h000, 33'h3);
    rd(12'h004, 33'h0);
    rd(12'h010, 33'h1_0000_0000);
    apb(1'b1, 12'h004, 32'h10);
    rd(12'h004, 33'h10);
    chk(quick_start_control, 1);
    $display("test registers done");
    for (int n = 0; n < 6; n++) begin
      r = xs();
      apb(1'b1, 12'h000, {r[31:8], 3'(n), 5'h00});
      run(256);
      chk(op_mode, 1);
      chk(c_sy >= 128 / (2 << n) - 1 && c_sy <= 128 / (2 << n) + 1, 1);
    end
    apb(1'b1, 12'h000, 32'h3);
    run(256);
    chk({op_mode, 8'(c_lc)}, 0);
    chk(c_sy >= 127 && c_sy <= 129, 1);
    apb(1'b1, 12'h000, 32'h7);
    run(512);
    chk(c_lc >= 7 && c_lc <= 9 && c_su >= 63 && c_su <= 65, 1);
    $display("test clocks done");
    apb(1'b1, 12'h00c, 32'h8);
    rd(12'h008, 33'h2);
    halt();
    chk({op_mode, cpu_run, 8'(c_sy)}, 33'h400);
    chk(c_su > 20 && c_pe > 20, 1);
    rd(12'h008, 33'h21);
    rd(12'h000, 33'h7);
    wake();
    chk(op_mode, 0);
    apb(1'b1, 12'h000, 32'h5);
    halt();
    chk(op_mode, 3);
    chk(c_lc + c_pe + c_sy == 0 && c_su > 20, 1);
    rd(12'h008, 33'h31);
    chk(ext_filter_enable, 1);
    wake();
    close_out();
  end
endmodule : clock_mode_power_down_control_bench
`default_nettype wire
